//--- rtl/aspbg_map.svh
// register offsets, field positions, reset values and frame counts of the serial port
// assumes a 32-bit apb slave with one aligned word per register
`ifndef ASPBG_MAP_SVH
`define ASPBG_MAP_SVH

`define ASPBG_OFF_CTRL     8'h00
`define ASPBG_OFF_DATA     8'h04
`define ASPBG_OFF_TCFG     8'h08
`define ASPBG_OFF_RELOAD   8'h0c
`define ASPBG_OFF_STATUS   8'h10
`define ASPBG_OFF_MASK     8'h14
`define ASPBG_OFF_COUNT    8'h18

`define ASPBG_CTRL_MODE    7
`define ASPBG_CTRL_ONE     6
`define ASPBG_CTRL_MCE     5
`define ASPBG_CTRL_REN     4
`define ASPBG_CTRL_TB8     3
`define ASPBG_CTRL_RB8     2
`define ASPBG_CTRL_TXDONE  1
`define ASPBG_CTRL_RXDONE  0

`define ASPBG_ST_TX        0
`define ASPBG_ST_RX        1

`define ASPBG_TCFG_RUN     0
`define ASPBG_TCFG_SEL_LO  1
`define ASPBG_TCFG_SEL_HI  3

`define ASPBG_RST_BYTE     8'h00
`define ASPBG_RST_FLAGS    2'h0
`define ASPBG_RST_SEL      3'h0

`define ASPBG_BITS_8BIT    4'ha
`define ASPBG_BITS_9BIT    4'hb
`define ASPBG_DATA_BITS    4'h8
`define ASPBG_TIMER_TOP    8'hff
`define ASPBG_DIV4_TOP     2'h3
`define ASPBG_DIV12_TOP    4'hb
`define ASPBG_DIV48_TOP    2'h3
`define ASPBG_DIV8_TOP     3'h7

`endif

//--- rtl/aspbg_pkg.sv
// types shared by the serial port and its baud timer
// assumes aspbg_map.svh is compiled alongside
`default_nettype none
package aspbg_pkg;
  typedef enum logic [2:0] {
    ASPBG_SRC_CORE,
    ASPBG_SRC_DIV4,
    ASPBG_SRC_DIV12,
    ASPBG_SRC_DIV48,
    ASPBG_SRC_EXT_OSC8,
    ASPBG_SRC_EXT_PIN
  } aspbg_clk_src_t;
  typedef enum {ASPBG_RX_IDLE, ASPBG_RX_START, ASPBG_RX_BITS} aspbg_rx_state_t;
endpackage
`default_nettype wire

//--- rtl/aspbg_baud_timer.sv
// baud timer: clock source prescaler, transmit low counter and hidden receive copy
// assumes ext_osc_clk and baud_timer_ext_input are synchronous to pclk
`include "aspbg_map.svh"
`default_nettype none
module aspbg_baud_timer
  import aspbg_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       timer_run,
  input  wire logic [2:0] clk_sel,
  input  wire logic [7:0] baud_timer_reload,
  input  wire logic       ext_osc_clk,
  input  wire logic       baud_timer_ext_input,
  input  wire logic       rx_force_reload,
  output logic [7:0]      baud_timer_low_count,
  output logic            tx_ovf,
  output logic            rx_ovf
);
  logic [1:0] div4_ff;
  logic [3:0] div12_ff;
  logic [1:0] div48_ff;
  logic [2:0] div8_ff;
  logic       osc_prev_ff;
  logic       pin_prev_ff;
  logic [7:0] rx_count_ff;
  logic       tick;
  logic       osc_rise;

  //////////////////////////////////////////////////////////////////////////////
  assign osc_rise = ext_osc_clk & ~osc_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4_ff     <= 2'h0;
      div12_ff    <= 4'h0;
      div48_ff    <= 2'h0;
      div8_ff     <= 3'h0;
      osc_prev_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      osc_prev_ff <= ext_osc_clk;
      pin_prev_ff <= baud_timer_ext_input;
      div4_ff     <= div4_ff + 2'h1;
      div12_ff    <= (div12_ff == `ASPBG_DIV12_TOP) ? 4'h0 : div12_ff + 4'h1;
      if (div12_ff == `ASPBG_DIV12_TOP)
        div48_ff <= div48_ff + 2'h1;
      if (osc_rise)
        div8_ff <= div8_ff + 3'h1;
    end
  end

  // six selectable sources; codes above five give no ticks, so the timer stalls
  always_comb begin
    unique case (clk_sel)
      ASPBG_SRC_CORE:     tick = 1'b1;
      ASPBG_SRC_DIV4:     tick = (div4_ff == `ASPBG_DIV4_TOP);
      ASPBG_SRC_DIV12:    tick = (div12_ff == `ASPBG_DIV12_TOP);
      ASPBG_SRC_DIV48:    tick = (div12_ff == `ASPBG_DIV12_TOP) && (div48_ff == `ASPBG_DIV48_TOP);
      ASPBG_SRC_EXT_OSC8: tick = osc_rise && (div8_ff == `ASPBG_DIV8_TOP);
      ASPBG_SRC_EXT_PIN:  tick = pin_prev_ff & ~baud_timer_ext_input;
      default:            tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // 8-bit auto-reload: overflow every 256 minus reload ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_timer_low_count <= `ASPBG_RST_BYTE;
      tx_ovf               <= 1'b0;
    end else begin
      tx_ovf <= 1'b0;
      if (timer_run && tick) begin
        if (baud_timer_low_count == `ASPBG_TIMER_TOP) begin
          baud_timer_low_count <= baud_timer_reload;
          tx_ovf               <= 1'b1;
        end else begin
          baud_timer_low_count <= baud_timer_low_count + 8'h01;
        end
      end
    end
  end

  // hidden copy with the same reload; a start edge forces it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_count_ff <= `ASPBG_RST_BYTE;
      rx_ovf      <= 1'b0;
    end else begin
      rx_ovf <= 1'b0;
      if (rx_force_reload) begin
        rx_count_ff <= baud_timer_reload;
      end else if (timer_run && tick) begin
        if (rx_count_ff == `ASPBG_TIMER_TOP) begin
          rx_count_ff <= baud_timer_reload;
          rx_ovf      <= 1'b1;
        end else begin
          rx_count_ff <= rx_count_ff + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/aspbg_top.sv
// asynchronous serial port with receive holding buffer, baud timer and apb registers
// assumes an apb master on pclk; rx_line and timer inputs are synchronous to pclk
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "aspbg_map.svh"
`default_nettype none
// Notes on behaviour
// - full duplex, 8-bit or 9-bit variable-baud framing
// - received byte held while next shifts in
// - data writes go tx, reads return rx
// - interrupt when tx or rx done sets
// - flags cleared only by software
// - baud from 8-bit auto-reload timer overflows
// - hidden rx timer copy, same reload
// - overflows halved into bit rates
// - start edge forces rx timer reload
// - six selectable baud timer clock sources
// - overflow rate clock over 256 minus reload
// - 8-bit frame: start, eight lsb-first, stop
// - 9-bit frame adds software ninth bit
// - load only if flag clear, filter passes
// - filter passes only ninth bit one
module aspbg_top
  import aspbg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  input  wire logic        ext_osc_clk,
  input  wire logic        baud_timer_ext_input,
  output logic             tx_line,
  output logic             irq
);
  logic [7:0]      serial_control_reg;
  logic            frame_mode_select_ff;
  logic            multiproc_filter_en_ff;
  logic            rx_enable_bit_ff;
  logic            tx_ninth_bit_ff;
  logic            rx_ninth_bit_ff;
  logic [1:0]      flags_ff;
  logic [1:0]      mask_ff;
  logic            timer_run_ff;
  logic [2:0]      clk_sel_ff;
  logic [7:0]      baud_timer_reload_ff;
  logic [7:0]      serial_data_buffer_ff;
  logic [7:0]      baud_timer_low_count;
  logic            tx_ovf;
  logic            rx_ovf;
  logic            wr_en;
  logic            rd_setup;
  logic            tx_done_set;
  logic            rx_done_set;
  logic [1:0]      flag_clr;
  logic [31:0]     nxt_rdata;
  logic            nxt_err;
  logic            tx_half_ff;
  logic            tx_bit_tick;
  logic [10:0]     tx_shift_ff;
  logic [3:0]      tx_left_ff;
  logic            rx_half_ff;
  logic            rx_sample;
  logic            rx_prev_ff;
  logic            rx_start;
  aspbg_rx_state_t rx_state_ff;
  logic [8:0]      rx_shift_ff;
  logic [3:0]      rx_cnt_ff;
  logic            rx_last_bit;
  logic            rx_accept;

  //////////////////////////////////////////////////////////////////////////////
  // apb: answer one cycle after setup, so every access phase lasts one cycle
  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `ASPBG_OFF_CTRL) || (a == `ASPBG_OFF_DATA) || (a == `ASPBG_OFF_TCFG) ||
                (a == `ASPBG_OFF_RELOAD) || (a == `ASPBG_OFF_STATUS) || (a == `ASPBG_OFF_MASK) ||
                (a == `ASPBG_OFF_COUNT);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  always_comb begin
    serial_control_reg                     = 8'h00;
    serial_control_reg[`ASPBG_CTRL_MODE]   = frame_mode_select_ff;
    serial_control_reg[`ASPBG_CTRL_ONE]    = 1'b1;
    serial_control_reg[`ASPBG_CTRL_MCE]    = multiproc_filter_en_ff;
    serial_control_reg[`ASPBG_CTRL_REN]    = rx_enable_bit_ff;
    serial_control_reg[`ASPBG_CTRL_TB8]    = tx_ninth_bit_ff;
    serial_control_reg[`ASPBG_CTRL_RB8]    = rx_ninth_bit_ff;
    serial_control_reg[`ASPBG_CTRL_TXDONE] = flags_ff[`ASPBG_ST_TX];
    serial_control_reg[`ASPBG_CTRL_RXDONE] = flags_ff[`ASPBG_ST_RX];
  end

  // reads of the data word return only the receive buffer
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      `ASPBG_OFF_CTRL:   nxt_rdata[7:0] = serial_control_reg;
      `ASPBG_OFF_DATA:   nxt_rdata[7:0] = serial_data_buffer_ff;
      `ASPBG_OFF_TCFG:   nxt_rdata[3:0] = {clk_sel_ff, timer_run_ff};
      `ASPBG_OFF_RELOAD: nxt_rdata[7:0] = baud_timer_reload_ff;
      `ASPBG_OFF_STATUS: nxt_rdata[1:0] = flags_ff;
      `ASPBG_OFF_MASK:   nxt_rdata[1:0] = mask_ff;
      `ASPBG_OFF_COUNT:  nxt_rdata[7:0] = baud_timer_low_count;
      default:           nxt_rdata      = 32'h0000_0000;
    endcase
    nxt_err = ~is_mapped(paddr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & nxt_err;
      if (rd_setup)
        prdata <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_mode_select_ff   <= 1'b0;
      multiproc_filter_en_ff <= 1'b0;
      rx_enable_bit_ff       <= 1'b0;
      tx_ninth_bit_ff        <= 1'b0;
      timer_run_ff           <= 1'b0;
      clk_sel_ff             <= `ASPBG_RST_SEL;
      baud_timer_reload_ff   <= `ASPBG_RST_BYTE;
      mask_ff                <= `ASPBG_RST_FLAGS;
    end else if (wr_en) begin
      if (hit(paddr, `ASPBG_OFF_CTRL)) begin
        frame_mode_select_ff   <= pwdata[`ASPBG_CTRL_MODE];
        multiproc_filter_en_ff <= pwdata[`ASPBG_CTRL_MCE];
        rx_enable_bit_ff       <= pwdata[`ASPBG_CTRL_REN];
        tx_ninth_bit_ff        <= pwdata[`ASPBG_CTRL_TB8];
      end
      if (hit(paddr, `ASPBG_OFF_TCFG)) begin
        timer_run_ff <= pwdata[`ASPBG_TCFG_RUN];
        clk_sel_ff   <= pwdata[`ASPBG_TCFG_SEL_HI:`ASPBG_TCFG_SEL_LO];
      end
      if (hit(paddr, `ASPBG_OFF_RELOAD))
        baud_timer_reload_ff <= pwdata[7:0];
      if (hit(paddr, `ASPBG_OFF_MASK))
        mask_ff <= pwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // done flags: hardware never clears them; a set beats a write-one clear
  assign flag_clr = (wr_en && hit(paddr, `ASPBG_OFF_STATUS)) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `ASPBG_RST_FLAGS;
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | {rx_done_set, tx_done_set};
    end
  end

  // level request while any unmasked done flag stands
  // follows the next flag value, so a set meeting a clear in one cycle still requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(((flags_ff & ~flag_clr) | {rx_done_set, tx_done_set}) & mask_ff);
  end

  //////////////////////////////////////////////////////////////////////////////
  aspbg_baud_timer u_baud (
    .pclk                 (pclk),
    .presetn              (presetn),
    .timer_run            (timer_run_ff),
    .clk_sel              (clk_sel_ff),
    .baud_timer_reload    (baud_timer_reload_ff),
    .ext_osc_clk          (ext_osc_clk),
    .baud_timer_ext_input (baud_timer_ext_input),
    .rx_force_reload      (rx_start),
    .baud_timer_low_count (baud_timer_low_count),
    .tx_ovf               (tx_ovf),
    .rx_ovf               (rx_ovf)
  );

  //////////////////////////////////////////////////////////////////////////////
  // transmitter: each bit lasts two transmit overflows
  assign tx_bit_tick = tx_ovf & tx_half_ff;
  assign tx_done_set = tx_bit_tick && (tx_left_ff == 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_half_ff <= 1'b0;
    else if (tx_ovf)
      tx_half_ff <= ~tx_half_ff;
  end

  // a data write loads the frame; writes while a frame is out are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_ff <= 11'h7ff;
      tx_left_ff  <= 4'h0;
      tx_line     <= 1'b1;
    end else if (wr_en && hit(paddr, `ASPBG_OFF_DATA) && (tx_left_ff == 4'h0)) begin
      if (frame_mode_select_ff) begin
        tx_shift_ff <= {1'b1, tx_ninth_bit_ff, pwdata[7:0], 1'b0};
        tx_left_ff  <= `ASPBG_BITS_9BIT;
      end else begin
        tx_shift_ff <= {2'h3, pwdata[7:0], 1'b0};
        tx_left_ff  <= `ASPBG_BITS_8BIT;
      end
    end else if (tx_bit_tick && (tx_left_ff != 4'h0)) begin
      // lsb first; the stop bit holds until the next bit tick
      tx_line     <= tx_shift_ff[0];
      tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
      tx_left_ff  <= tx_left_ff - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver: start edge reloads rx timer; first overflow lands mid start bit
  assign rx_start    = (rx_state_ff == ASPBG_RX_IDLE) && rx_enable_bit_ff && rx_prev_ff && !rx_line;
  assign rx_sample   = rx_ovf & ~rx_half_ff;
  // ninth sample after the start: the stop in 8-bit framing, the ninth bit in 9-bit framing
  // ending on the ninth bit leaves the 9-bit stop unchecked, which that framing allows
  assign rx_last_bit = (rx_cnt_ff == `ASPBG_DATA_BITS);
  // last sampled bit is the stop in 8-bit and the ninth in 9-bit framing
  assign rx_accept   = !flags_ff[`ASPBG_ST_RX] && (!multiproc_filter_en_ff || rx_line);
  assign rx_done_set = (rx_state_ff == ASPBG_RX_BITS) && rx_sample && rx_last_bit && rx_accept;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_prev_ff <= 1'b1;
    else
      rx_prev_ff <= rx_line;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_half_ff <= 1'b0;
    else if (rx_start)
      rx_half_ff <= 1'b0;
    else if (rx_ovf)
      rx_half_ff <= ~rx_half_ff;
  end

  // ninth-bit frames finish at the ninth bit; the stop bit is then not checked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= ASPBG_RX_IDLE;
      rx_shift_ff <= 9'h000;
      rx_cnt_ff   <= 4'h0;
    end else begin
      unique case (rx_state_ff)
        ASPBG_RX_IDLE: begin
          if (rx_start)
            rx_state_ff <= ASPBG_RX_START;
        end
        ASPBG_RX_START: begin
          if (rx_sample) begin
            // a high line mid start bit is a glitch, not a frame
            rx_state_ff <= rx_line ? ASPBG_RX_IDLE : ASPBG_RX_BITS;
            rx_cnt_ff   <= 4'h0;
          end
        end
        ASPBG_RX_BITS: begin
          if (rx_sample) begin
            rx_shift_ff <= {rx_line, rx_shift_ff[8:1]};
            rx_cnt_ff   <= rx_cnt_ff + 4'h1;
            if (rx_last_bit)
              rx_state_ff <= ASPBG_RX_IDLE;
          end
        end
      endcase
    end
  end

  // holding buffer only changes at frame end, so a new frame may shift in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_data_buffer_ff <= `ASPBG_RST_BYTE;
      rx_ninth_bit_ff       <= 1'b0;
    end else if (rx_done_set) begin
      // data sit one place up, since the final sample is not shifted in yet
      serial_data_buffer_ff <= rx_shift_ff[8:1];
      rx_ninth_bit_ff       <= rx_line;
    end
  end
endmodule
`default_nettype wire

//--- sim/aspbg_remote.sv
// remote transceiver on the serial lines: sends frames, captures the port's frames
// assumes the bench calls send and reads the capture variables by hierarchy
`default_nettype none
module aspbg_remote (
  input  wire logic pclk,
  input  wire logic tx_line,
  input  wire logic nine_mode,
  output var  logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  got_byte;
  logic        got_ninth;
  logic        got_stop;
  logic [15:0] got_period;
  int          frames = 0;
  initial rx_line = 1'b1;
  ////////////////////////
  // start, lsb-first data, optional ninth, stop
  task automatic send(input logic [7:0] b, input logic nine, input logic use9, input int cyc);
    logic [10:0] fr;
    int          n;
    fr = use9 ? {1'b1, nine, b, 1'b0} : {2'b11, b, 1'b0};
    n = use9 ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_line <= fr[i];
      repeat (cyc - 1) @(posedge pclk);
    end
    @(posedge pclk);
  endtask
  ////////////////////////
  // start bit length sets the sampling pitch, so a wrong baud shows as a wrong period
  initial begin
    int         cnt;
    int         n;
    logic [9:0] bits;
    forever begin
      @(negedge tx_line);
      cnt = 0;
      @(negedge pclk);
      while (tx_line === 1'b0) begin
        cnt++;
        @(negedge pclk);
      end
      n = nine_mode ? 10 : 9;
      repeat (cnt / 2) @(negedge pclk);
      for (int i = 0; i < n; i++) begin
        bits[i] = tx_line;
        if (i < n - 1) repeat (cnt) @(negedge pclk);
      end
      got_byte = bits[7:0];
      got_ninth = bits[8];
      got_stop = bits[n-1];
      got_period = cnt[15:0];
      frames++;
    end
  end
endmodule
`default_nettype wire

//--- sim/aspbg_props.sv
// concurrent checks on the apb, irq and tx pins of the serial port
// assumes one pclk domain, presetn asynchronous active low, reload at most 8'hfc
`include "aspbg_map.svh"
`default_nettype none
module aspbg_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_line,
  input wire logic        ext_osc_clk,
  input wire logic        baud_timer_ext_input,
  input wire logic        tx_line,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_rd;
    s_done ##0 !pwrite;
  endsequence
  ////////////////////////
  a_pready_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_pready_once: assert property (pready |-> psel && penable ##1 !pready) else $error("pready stray");
  a_hole_err: assert property (s_done ##0 (paddr > `ASPBG_OFF_COUNT) |-> pslverr)
    else $error("unmapped without error");
  a_map_ok: assert property (s_done ##0 (paddr <= `ASPBG_OFF_COUNT) ##0 (paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped with error");
  a_hole_zero: assert property (s_rd ##0 (paddr > `ASPBG_OFF_COUNT) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_narrow: assert property (s_rd |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_ctrl_one: assert property (s_rd ##0 (paddr == `ASPBG_OFF_CTRL) |-> prdata[6])
    else $error("ctrl bit six low");
  a_mask_quiet: assert property (s_done ##0 pwrite ##0 (paddr == `ASPBG_OFF_MASK) ##0 (pwdata[1:0] == 2'h0)
    |=> ##1 !irq) else $error("irq with mask clear");
  a_start_len: assert property ($fell(tx_line) |-> !tx_line [*8]) else $error("start bit short");
endmodule
bind aspbg_top aspbg_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .ext_osc_clk(ext_osc_clk), .baud_timer_ext_input(baud_timer_ext_input),
  .tx_line(tx_line), .irq(irq)
);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench: apb register traffic and a remote transceiver on the lines
// assumes the design, the checker and aspbg_remote are compiled before it
`include "aspbg_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RLD = 8'hfc;
  localparam int         BITC = 8;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, rx_line, tx_line, irq, last_err;
  logic        ext_ff = 1'b0, nine_mode = 1'b0;
  int          err_count = 0, samples_checked = 0;
  always #10 pclk = ~pclk;
  // both external sources see an edge every two cycles
  always @(posedge pclk) ext_ff <= ~ext_ff;
  aspbg_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .ext_osc_clk(ext_ff), .baud_timer_ext_input(ext_ff), .tx_line(tx_line), .irq(irq));
  aspbg_remote remote (.pclk(pclk), .tx_line(tx_line), .nine_mode(nine_mode), .rx_line(rx_line));
  ////////////////////////
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_link(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t line got=%h exp=%h", $time, got, exp);
    end
  endtask
  // setup, then access held until pready is sampled high at a rising edge; released right after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) err_count++;
    rd_q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(rd_q, e);
  endtask
  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (remote.frames < n && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20000) err_count++;
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    int per [5];
    per = '{32, 96, 384, 128, 16};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ASPBG_OFF_CTRL, 32'h40);
    rd(`ASPBG_OFF_STATUS, 32'h0);
    rd(`ASPBG_OFF_DATA, 32'h0);
    rd(`ASPBG_OFF_COUNT, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk_reg({31'h0, last_err}, 32'h1);
    wr(`ASPBG_OFF_RELOAD, {24'h0, RLD});
    wr(`ASPBG_OFF_TCFG, 32'h1);
    wr(`ASPBG_OFF_MASK, 32'h3);
    wr(`ASPBG_OFF_CTRL, 32'h10);
    wr(`ASPBG_OFF_DATA, 32'h55);
    wr(`ASPBG_OFF_DATA, 32'h0f);
    wait_frames(1);
    chk_link({8'h0, remote.got_byte}, 16'h55);
    chk_link(remote.got_period, 16'(BITC));
    chk_link({15'h0, remote.got_stop}, 16'h1);
    repeat (12 * BITC) @(posedge pclk);
    chk_link(16'(remote.frames), 16'h1);
    rd(`ASPBG_OFF_CTRL, 32'h52);
    chk_reg({31'h0, irq}, 32'h1);
    wr(`ASPBG_OFF_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk_reg({31'h0, irq}, 32'h0);
    // the other five sources stretch the bit; a bad divider shows as a wrong period
    for (int s = 1; s < 6; s++) begin
      wr(`ASPBG_OFF_TCFG, 32'(s * 2 + 1));
      wr(`ASPBG_OFF_DATA, 32'h55);
      wait_frames(s + 1);
      chk_link(remote.got_period, 16'(per[s-1]));
      wr(`ASPBG_OFF_STATUS, 32'h1);
    end
    wr(`ASPBG_OFF_TCFG, 32'h1);
    // start edges land at three offsets of the overflow period
    for (int i = 0; i < 3; i++) begin
      repeat (i + 1) @(posedge pclk);
      remote.send(8'hc3 ^ 8'(i), 1'b0, 1'b0, BITC);
      repeat (4) @(posedge pclk);
      rd(`ASPBG_OFF_STATUS, 32'h2);
      chk_reg({31'h0, irq}, 32'h1);
      rd(`ASPBG_OFF_DATA, {24'h0, 8'hc3 ^ 8'(i)});
      wr(`ASPBG_OFF_STATUS, 32'h2);
    end
    remote.send(8'h3a, 1'b0, 1'b0, BITC);
    remote.send(8'h44, 1'b0, 1'b0, BITC);
    rd(`ASPBG_OFF_DATA, 32'h3a);
    rd(`ASPBG_OFF_CTRL, 32'h55);
    wr(`ASPBG_OFF_STATUS, 32'h2);
    wr(`ASPBG_OFF_CTRL, 32'h0);
    remote.send(8'h77, 1'b0, 1'b0, BITC);
    rd(`ASPBG_OFF_STATUS, 32'h0);
    nine_mode <= 1'b1;
    wr(`ASPBG_OFF_CTRL, 32'h98);
    // bit 0 set, so the model can time the start bit on its own
    wr(`ASPBG_OFF_DATA, 32'h69);
    wait_frames(7);
    chk_link({8'h0, remote.got_byte}, 16'h69);
    chk_link({15'h0, remote.got_ninth}, 16'h1);
    wr(`ASPBG_OFF_STATUS, 32'h1);
    wr(`ASPBG_OFF_CTRL, 32'hb0);
    remote.send(8'h12, 1'b0, 1'b1, BITC);
    rd(`ASPBG_OFF_STATUS, 32'h0);
    remote.send(8'h34, 1'b1, 1'b1, BITC);
    rd(`ASPBG_OFF_STATUS, 32'h2);
    rd(`ASPBG_OFF_DATA, 32'h34);
    rd(`ASPBG_OFF_CTRL, 32'hf5);
    wr(`ASPBG_OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk_reg({31'h0, irq}, 32'h0);
    rd(`ASPBG_OFF_STATUS, 32'h2);
    report_and_stop();
  end
endmodule
`default_nettype wire
